// *** shared/spis_pkg.sv ***
// constants, register map and types of the semaphore spi slave
package spis_pkg;
	localparam int CNT_W = 14;
	localparam int PTR_W = 32;
	localparam int ADDR_W = 12;

	localparam logic [ADDR_W-1:0] OFS_TASK_ACQUIRE  = 12'h024;
	localparam logic [ADDR_W-1:0] OFS_TASK_RELEASE  = 12'h028;
	localparam logic [ADDR_W-1:0] OFS_EV_DONE       = 12'h104;
	localparam logic [ADDR_W-1:0] OFS_EV_RX_FULL    = 12'h110;
	localparam logic [ADDR_W-1:0] OFS_EV_ACQUIRED   = 12'h128;
	localparam logic [ADDR_W-1:0] OFS_SHORTCUT      = 12'h200;
	localparam logic [ADDR_W-1:0] OFS_SEM_STATE     = 12'h400;
	localparam logic [ADDR_W-1:0] OFS_STATUS        = 12'h440;
	localparam logic [ADDR_W-1:0] OFS_ENABLE        = 12'h500;
	localparam logic [ADDR_W-1:0] OFS_RX_POINTER    = 12'h534;
	localparam logic [ADDR_W-1:0] OFS_RX_LIMIT      = 12'h538;
	localparam logic [ADDR_W-1:0] OFS_RX_COUNT      = 12'h53c;
	localparam logic [ADDR_W-1:0] OFS_TX_POINTER    = 12'h544;
	localparam logic [ADDR_W-1:0] OFS_TX_LIMIT      = 12'h548;
	localparam logic [ADDR_W-1:0] OFS_TX_COUNT      = 12'h54c;
	localparam logic [ADDR_W-1:0] OFS_CONFIG        = 12'h554;
	localparam logic [ADDR_W-1:0] OFS_IGNORED_FILL  = 12'h55c;
	localparam logic [ADDR_W-1:0] OFS_TX_FLAG_A_FILL = 12'h5c0;

	localparam int STAT_TX_FLAG_A_BIT = 0;
	localparam int STAT_OVERFLOW_BIT = 1;
	localparam int CFG_LSB_FIRST_BIT = 0;
	localparam int CFG_PHASE_BIT     = 1;
	localparam int CFG_IDLE_BIT      = 2;

	// pin sync order: select, clock, data in; select idles high
	localparam int SYNC_SEL = 2;
	localparam int SYNC_CLK = 1;
	localparam int SYNC_DIN = 0;
	localparam logic [2:0] SYNC_RESET = 3'h4;

	typedef enum logic [1:0] {SEM_FREE, SEM_CPU, SEM_SLAVE} sem_e;
	typedef enum logic [1:0] {MODE_IDLE, MODE_IGNORED, MODE_GRANTED} mode_e;
endpackage : spis_pkg

// *** verilog/pin_sync.sv ***
// two-stage synchronisers and edge finders for the spi pins
`timescale 1ns/10ps
module pin_sync
	import spis_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic [2:0] pinRaw,
	output logic      [2:0] pinLevel,
	output logic      [2:0] pinRise,
	output logic      [2:0] pinFall
);
	typedef struct packed {
		logic [2:0] first;
		logic [2:0] second;
		logic [2:0] third;
	} sync_s;

	sync_s s;
	sync_s next_s;

	always_comb begin
		next_s        = s;
		next_s.first  = pinRaw;
		next_s.second = s.first;
		next_s.third  = s.second;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s <= {SYNC_RESET, SYNC_RESET, SYNC_RESET};
		end else begin
			s <= next_s;
		end
	end

	assign pinLevel = s.second;
	assign pinRise  = s.second & ~s.third;
	assign pinFall  = ~s.second & s.third;
endmodule : pin_sync

// *** verilog/sem_arbiter.sv ***
// buffer semaphore shared by the cpu and the spi slave
`timescale 1ns/10ps
module sem_arbiter
	import spis_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic enable,
	input  wire logic shortcut,
	input  wire logic acquireTask,
	input  wire logic releaseTask,
	input  wire logic slaveReq,
	input  wire logic slaveDone,
	output logic      slaveGrant,
	output logic      acquiredEvt,
	output sem_e      owner
);
	typedef struct packed {
		sem_e owner;
		logic pending;
		logic acqEvt;
	} sem_s;

	sem_s s;
	sem_s next_s;

	// cpu wins a same-cycle race
	assign slaveGrant = slaveReq && s.owner == SEM_FREE && !acquireTask;

	always_comb begin
		next_s        = s;
		next_s.acqEvt = 1'b0;
		if (!enable) begin
			next_s.owner   = SEM_CPU;
			next_s.pending = 1'b0;
		end else begin
			if (slaveGrant) begin
				next_s.owner = SEM_SLAVE;
			end
			if (acquireTask) begin
				case (s.owner)
					SEM_CPU: next_s.acqEvt = 1'b1;
					SEM_FREE: begin
						next_s.owner  = SEM_CPU;
						next_s.acqEvt = 1'b1;
					end
					SEM_SLAVE: next_s.pending = 1'b1;
					default: next_s.pending = s.pending;
				endcase
			end
			if (releaseTask && s.owner == SEM_CPU) begin
				next_s.owner = SEM_FREE;
			end
			if (slaveDone && s.owner == SEM_SLAVE) begin
				// one handover, however many requests
				if (s.pending || acquireTask || shortcut) begin
					next_s.owner  = SEM_CPU;
					next_s.acqEvt = 1'b1;
				end else begin
					next_s.owner = SEM_FREE;
				end
				next_s.pending = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s <= '{owner: SEM_CPU, pending: 1'b0, acqEvt: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign acquiredEvt = s.acqEvt;
	assign owner       = s.owner;

	a_cpu_wins: assert property (@(posedge ref_clk) disable iff (!rst_n)
		enable && slaveReq && acquireTask && s.owner == SEM_FREE
		|=> s.owner == SEM_CPU) else $error("race not won by cpu");
	a_cpu_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
		enable && s.owner == SEM_CPU && !releaseTask
		|=> s.owner == SEM_CPU) else $error("cpu lost semaphore");
	a_release_noop: assert property (@(posedge ref_clk) disable iff (!rst_n)
		enable && releaseTask && s.owner == SEM_SLAVE && !slaveDone
		|=> s.owner == SEM_SLAVE && !s.acqEvt)
		else $error("stray release acted");
	a_acq_now: assert property (@(posedge ref_clk) disable iff (!rst_n)
		enable && acquireTask && s.owner == SEM_CPU |=> s.acqEvt)
		else $error("no immediate acquired event");
	a_init_cpu: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!enable ##1 enable |-> s.owner == SEM_CPU && !s.acqEvt)
		else $error("bad initial owner");
	a_pend_grant: assert property (@(posedge ref_clk) disable iff (!rst_n)
		enable && s.owner == SEM_SLAVE && s.pending && slaveDone
		|=> s.owner == SEM_CPU && s.acqEvt)
		else $error("held request not served");
	a_one_handover: assert property (@(posedge ref_clk) disable iff (!rst_n)
		enable && s.owner == SEM_SLAVE && slaveDone && shortcut && s.pending
		##1 !acquireTask |=> !s.acqEvt)
		else $error("request served twice");
endmodule : sem_arbiter

// *** verilog/spi_slave_dma.sv ***
// spi slave with semaphore-guarded buffer access
//
// How it works
// - idle level and sample phase bits select any of spi modes 0 to 3
// - a reader fetches transmit bytes, a writer stores receive bytes
// - select falling tries the semaphore; failure makes the frame ignored
// - ignored frames drop input and send the ignored fill byte
// - an ignored frame stays ignored until select rises
// - a same-cycle race for the semaphore goes to the cpu
// - granted frames store input and send transmit buffer bytes
// - granted frame end frees the semaphore and raises the done event
// - an acquire task hands the semaphore to the cpu with an event
// - only a release task from the cpu frees a cpu-held semaphore
// - release without cpu ownership does nothing
// - pointers and memory stay writable whoever holds the semaphore
// - on enable the cpu holds the semaphore, no event
// - acquire while the cpu holds it raises the event at once
// - unchanged pointers are reused for every granted frame
// - shortcut hands the semaphore to the cpu at frame end
// - acquire during a slave-held frame is served at frame end
// - shortcut plus held request gives a single handover
// - bytes past the receive limit set overflow and are dropped
// - bytes past the transmit limit set over-read and send its fill byte
// - byte counts update at granted frame end, fill bytes excluded
// - the receive full event rises when the last buffer byte is stored
// - data out is not driven while select is high
`timescale 1ns/10ps
module spi_slave_dma
	import spis_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] regAddr,
	input  wire logic [31:0]       regWrData,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [31:0]       regRdData,
	input  wire logic              selectLineN,
	input  wire logic              spiClk,
	input  wire logic              spiMosi,
	output logic                   spiMiso,
	output logic                   spiMisoEn,
	output logic      [PTR_W-1:0]  memAddr,
	output logic      [7:0]        memWrData,
	output logic                   memWr,
	output logic                   memRd,
	input  wire logic [7:0]        memRdData
);
	typedef struct packed {
		mode_e            mode;
		logic [2:0]       bitCnt;
		logic [7:0]       rxShift;
		logic [7:0]       txCur;
		logic [7:0]       txNext;
		logic             haveCur;
		logic             fetchPend;
		logic             rdWait;
		logic [CNT_W-1:0] fetchIdx;
		logic [CNT_W-1:0] bytesDone;
		logic             misoBit;
		logic             misoEn;
		logic [PTR_W-1:0] memAddr;
		logic [7:0]       memWrData;
		logic             memWr;
		logic             memRd;
		logic [31:0]      rdData;
		logic             enable;
		logic             shortEn;
		logic             lsbFirst;
		logic             clockSamplePhase;
		logic             clockIdleLevel;
		logic             evDone;
		logic             rxBufferFullEvent;
		logic             evAcquired;
		logic             txFlagA;
		logic             overflow;
		logic [PTR_W-1:0] rxBufferPointer;
		logic [PTR_W-1:0] txBufferPointer;
		logic [CNT_W-1:0] rxByteLimit;
		logic [CNT_W-1:0] txByteLimit;
		logic [CNT_W-1:0] rxByteCount;
		logic [CNT_W-1:0] txByteCount;
		logic [7:0]       ignoredFillByte;
		logic [7:0]       overreadFillByte;
	} slave_s;

	slave_s s;
	slave_s next_s;

	logic [2:0] pinLevel;
	logic [2:0] pinRise;
	logic [2:0] pinFall;
	logic       slaveReq;
	logic       slaveDone;
	logic       slaveGrant;
	logic       acquiredEvt;
	sem_e       owner;
	logic       acquireTask;
	logic       releaseTask;
	logic       leadEdge;
	logic       trailEdge;
	logic       sampleEdge;
	logic       shiftEdge;
	logic       selFall;
	logic       selRise;

	function automatic logic pickBit(input logic [7:0] b,
		input logic [2:0] idx, input logic lsb);
		pickBit = lsb ? b[idx] : b[3'h7 - idx];
	endfunction : pickBit

	function automatic logic [7:0] shiftIn(input logic [7:0] sh,
		input logic din, input logic lsb);
		shiftIn = lsb ? {din, sh[7:1]} : {sh[6:0], din};
	endfunction : shiftIn

	function automatic logic [CNT_W-1:0] minCnt(input logic [CNT_W-1:0] a,
		input logic [CNT_W-1:0] b);
		minCnt = (a < b) ? a : b;
	endfunction : minCnt

	function automatic logic [PTR_W-1:0] bufAddr(input logic [PTR_W-1:0] p,
		input logic [CNT_W-1:0] i);
		bufAddr = p + {{(PTR_W-CNT_W){1'b0}}, i};
	endfunction : bufAddr

	pin_sync u_sync (
		.ref_clk  (ref_clk),
		.rst_n    (rst_n),
		.pinRaw   ({selectLineN, spiClk, spiMosi}),
		.pinLevel (pinLevel),
		.pinRise  (pinRise),
		.pinFall  (pinFall)
	);

	sem_arbiter u_sem (
		.ref_clk     (ref_clk),
		.rst_n       (rst_n),
		.enable      (s.enable),
		.shortcut    (s.shortEn),
		.acquireTask (acquireTask),
		.releaseTask (releaseTask),
		.slaveReq    (slaveReq),
		.slaveDone   (slaveDone),
		.slaveGrant  (slaveGrant),
		.acquiredEvt (acquiredEvt),
		.owner       (owner)
	);

	assign acquireTask = regWr && regAddr == OFS_TASK_ACQUIRE && regWrData[0];
	assign releaseTask = regWr && regAddr == OFS_TASK_RELEASE && regWrData[0];
	assign selFall     = pinFall[SYNC_SEL];
	assign selRise     = pinRise[SYNC_SEL];
	// leading edge leaves the idle level
	assign leadEdge    = s.clockIdleLevel ? pinFall[SYNC_CLK] : pinRise[SYNC_CLK];
	assign trailEdge   = s.clockIdleLevel ? pinRise[SYNC_CLK] : pinFall[SYNC_CLK];
	assign sampleEdge  = s.clockSamplePhase ? trailEdge : leadEdge;
	assign shiftEdge   = s.clockSamplePhase ? leadEdge : trailEdge;

	always_comb begin
		logic [7:0]  rxByte;
		logic [7:0]  fillVal;
		logic        deliver;
		logic        wroteNow;
		logic [31:0] rv;
		rxByte    = 8'h00;
		fillVal   = 8'h00;
		deliver   = 1'b0;
		wroteNow  = 1'b0;
		rv        = 32'h0;
		slaveReq  = 1'b0;
		slaveDone = 1'b0;
		next_s        = s;
		next_s.memWr  = 1'b0;
		next_s.memRd  = 1'b0;
		next_s.rdWait = s.memRd;
		next_s.misoEn = !pinLevel[SYNC_SEL] && s.enable;

		// registers stay writable in any semaphore state
		if (regWr) begin
			case (regAddr)
				OFS_EV_DONE:       next_s.evDone = regWrData[0];
				OFS_EV_RX_FULL:    next_s.rxBufferFullEvent = regWrData[0];
				OFS_EV_ACQUIRED:   next_s.evAcquired = regWrData[0];
				OFS_SHORTCUT:      next_s.shortEn = regWrData[0];
				OFS_ENABLE:        next_s.enable = regWrData[0];
				OFS_RX_POINTER:    next_s.rxBufferPointer = regWrData;
				OFS_RX_LIMIT:      next_s.rxByteLimit = regWrData[CNT_W-1:0];
				OFS_TX_POINTER:    next_s.txBufferPointer = regWrData;
				OFS_TX_LIMIT:      next_s.txByteLimit = regWrData[CNT_W-1:0];
				OFS_IGNORED_FILL:  next_s.ignoredFillByte = regWrData[7:0];
				OFS_TX_FLAG_A_FILL: next_s.overreadFillByte = regWrData[7:0];
				OFS_CONFIG: begin
					next_s.lsbFirst = regWrData[CFG_LSB_FIRST_BIT];
					next_s.clockSamplePhase = regWrData[CFG_PHASE_BIT];
					next_s.clockIdleLevel = regWrData[CFG_IDLE_BIT];
				end
				OFS_STATUS: begin
					// write one to clear
					if (regWrData[STAT_TX_FLAG_A_BIT]) next_s.txFlagA = 1'b0;
					if (regWrData[STAT_OVERFLOW_BIT]) next_s.overflow = 1'b0;
				end
				default: rv = 32'h0;
			endcase
		end
		if (acquiredEvt) begin
			next_s.evAcquired = 1'b1;
		end

		case (s.mode)
			MODE_IDLE: begin
				if (selFall && s.enable) begin
					slaveReq = 1'b1;
					next_s.bitCnt = 3'h0;
					next_s.bytesDone = '0;
					next_s.fetchIdx = '0;
					next_s.haveCur = 1'b0;
					next_s.rxShift = 8'h00;
					if (slaveGrant) begin
						next_s.mode = MODE_GRANTED;
						next_s.fetchPend = 1'b1;
					end else begin
						next_s.mode = MODE_IGNORED;
						next_s.txCur = s.ignoredFillByte;
						next_s.haveCur = 1'b1;
						if (!s.clockSamplePhase) begin
							next_s.misoBit = pickBit(s.ignoredFillByte, 3'h0,
								s.lsbFirst);
						end
					end
				end
			end
			MODE_IGNORED: begin
				if (shiftEdge) begin
					next_s.misoBit = pickBit(s.txCur, s.bitCnt, s.lsbFirst);
				end
				if (sampleEdge) begin
					next_s.bitCnt = s.bitCnt + 3'h1;
				end
				if (selRise) begin
					next_s.mode = MODE_IDLE;
				end
			end
			MODE_GRANTED: begin
				if (sampleEdge) begin
					rxByte = shiftIn(s.rxShift, pinLevel[SYNC_DIN], s.lsbFirst);
					next_s.rxShift = rxByte;
					next_s.bitCnt = s.bitCnt + 3'h1;
					if (s.bitCnt == 3'h7) begin
						next_s.bytesDone = s.bytesDone + 14'h1;
						next_s.txCur = s.txNext;
						next_s.fetchPend = 1'b1;
						if (s.bytesDone < s.rxByteLimit) begin
							next_s.memWr = 1'b1;
							next_s.memAddr = bufAddr(s.rxBufferPointer,
								s.bytesDone);
							next_s.memWrData = rxByte;
							wroteNow = 1'b1;
							if (s.bytesDone + 14'h1 == s.rxByteLimit) begin
								next_s.rxBufferFullEvent = 1'b1;
							end
						end
					end
				end
				if (shiftEdge) begin
					next_s.misoBit = pickBit(s.txCur, s.bitCnt, s.lsbFirst);
				end
				if (s.rdWait) begin
					deliver = 1'b1;
					fillVal = memRdData;
				end else if (s.fetchPend && !wroteNow) begin
					next_s.fetchPend = 1'b0;
					if (s.fetchIdx < s.txByteLimit) begin
						next_s.memRd = 1'b1;
						next_s.memAddr = bufAddr(s.txBufferPointer, s.fetchIdx);
						next_s.fetchIdx = s.fetchIdx + 14'h1;
					end else begin
						deliver = 1'b1;
						fillVal = s.overreadFillByte;
					end
				end
				if (deliver) begin
					if (!s.haveCur) begin
						next_s.txCur = fillVal;
						next_s.haveCur = 1'b1;
						next_s.fetchPend = 1'b1;
						if (!s.clockSamplePhase) begin
							next_s.misoBit = pickBit(fillVal, 3'h0, s.lsbFirst);
						end
					end else begin
						next_s.txNext = fillVal;
					end
				end
				if (selRise) begin
					next_s.mode = MODE_IDLE;
					slaveDone = 1'b1;
					next_s.evDone = 1'b1;
					next_s.fetchPend = 1'b0;
					next_s.rxByteCount = minCnt(s.bytesDone, s.rxByteLimit);
					next_s.txByteCount = minCnt(s.bytesDone, s.txByteLimit);
					if (s.bytesDone > s.rxByteLimit) begin
						next_s.overflow = 1'b1;
					end
					if (s.bytesDone > s.txByteLimit) begin
						next_s.txFlagA = 1'b1;
					end
				end
			end
			default: next_s.mode = MODE_IDLE;
		endcase
		if (!s.enable) begin
			next_s.mode = MODE_IDLE;
		end

		case (regAddr)
			OFS_EV_DONE:       rv = {31'h0, s.evDone};
			OFS_EV_RX_FULL:    rv = {31'h0, s.rxBufferFullEvent};
			OFS_EV_ACQUIRED:   rv = {31'h0, s.evAcquired};
			OFS_SHORTCUT:      rv = {31'h0, s.shortEn};
			OFS_SEM_STATE:     rv = {30'h0, owner};
			OFS_STATUS:        rv = {30'h0, s.overflow, s.txFlagA};
			OFS_ENABLE:        rv = {31'h0, s.enable};
			OFS_RX_POINTER:    rv = s.rxBufferPointer;
			OFS_RX_LIMIT:      rv = {18'h0, s.rxByteLimit};
			OFS_RX_COUNT:      rv = {18'h0, s.rxByteCount};
			OFS_TX_POINTER:    rv = s.txBufferPointer;
			OFS_TX_LIMIT:      rv = {18'h0, s.txByteLimit};
			OFS_TX_COUNT:      rv = {18'h0, s.txByteCount};
			OFS_CONFIG:        rv = {29'h0, s.clockIdleLevel, s.clockSamplePhase,
				s.lsbFirst};
			OFS_IGNORED_FILL:  rv = {24'h0, s.ignoredFillByte};
			OFS_TX_FLAG_A_FILL: rv = {24'h0, s.overreadFillByte};
			default:           rv = 32'h0;
		endcase
		next_s.rdData = regRd ? rv : 32'h0;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign regRdData = s.rdData;
	assign spiMiso   = s.misoBit;
	assign spiMisoEn = s.misoEn;
	assign memAddr   = s.memAddr;
	assign memWrData = s.memWrData;
	assign memWr     = s.memWr;
	assign memRd     = s.memRd;

	a_miso_hiz: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pinLevel[SYNC_SEL] |=> !spiMisoEn) else $error("miso driven");
	a_ignored_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s.mode == MODE_IGNORED |=> !memWr && !memRd)
		else $error("memory touched in ignored frame");
	a_stay_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s.mode == MODE_IGNORED && !selRise && s.enable
		|=> s.mode == MODE_IGNORED) else $error("ignored frame left");
	a_done_event: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s.mode == MODE_GRANTED && selRise && s.enable
		|=> s.evDone && s.mode == MODE_IDLE) else $error("no done event");
	a_rx_limit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s.mode == MODE_GRANTED && sampleEdge && s.bitCnt == 3'h7
		&& s.bytesDone >= s.rxByteLimit |=> !memWr)
		else $error("write past receive limit");
	a_counts: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s.mode == MODE_GRANTED && selRise && s.enable
		|=> s.txByteCount == minCnt($past(s.bytesDone), s.txByteLimit))
		else $error("bad transmit count");
	a_busy_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s.mode == MODE_GRANTED |-> owner == SEM_SLAVE)
		else $error("granted frame without semaphore");

	c_granted: cover property (@(posedge ref_clk) disable iff (!rst_n)
		s.mode == MODE_GRANTED ##[1:400] s.evDone);
	c_ignored: cover property (@(posedge ref_clk) disable iff (!rst_n)
		s.mode == MODE_IGNORED ##[1:400] s.mode == MODE_IDLE);
	c_overflow: cover property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(s.overflow));
	c_tx_flag_a: cover property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(s.txFlagA));
endmodule : spi_slave_dma

// *** dv/spi_master_model.sv ***
// behavioural spi master that frames bytes and collects returned bytes
`timescale 1ns/10ps
module spi_master_model (
	output logic     selectLineN,
	output logic     spiClk,
	output logic     spiMosi,
	input  wire logic spiMiso
);
	logic [7:0] sendQ[$];
	logic [7:0] gotQ[$];
	logic       clock_idle_level;
	logic       clock_sample_phase;

	initial begin
		selectLineN = 1'h1;
		spiClk = 1'h0;
		spiMosi = 1'h0;
		clock_idle_level = 1'h0;
		clock_sample_phase = 1'h0;
	end

	// clock idles at the polarity level outside frames
	task automatic setMode(input logic pol, input logic pha);
		clock_idle_level = pol;
		clock_sample_phase = pha;
		spiClk = pol;
	endtask : setMode

	task automatic frame(input int nBits);
		logic [7:0] r;
		logic       b;
		gotQ.delete();
		#7 selectLineN = 1'h0;
		#400;
		for (int i = 0; i < nBits; i++) begin
			b = sendQ[i / 8][7 - i % 8];
			if (!clock_sample_phase)
				spiMosi = b;
			#100 spiClk = !clock_idle_level;
			if (clock_sample_phase)
				spiMosi = b;
			else
				r = {r[6:0], spiMiso};
			#100 spiClk = clock_idle_level;
			if (clock_sample_phase)
				r = {r[6:0], spiMiso};
			if (i % 8 == 7)
				gotQ.push_back(r);
		end
		#200 selectLineN = 1'h1;
		// released data line must not keep its last value
		spiMosi = !spiMosi;
		#400;
	endtask : frame
endmodule : spi_master_model

// *** dv/spi_slave_semaphore_dma_tb_top.sv ***
// self-checking bench of the semaphore spi slave
`timescale 1ns/10ps
module spi_slave_semaphore_dma_tb_top;
	import spis_pkg::*;
	logic              ref_clk;
	logic              rst_n;
	logic [ADDR_W-1:0] regAddr;
	logic [31:0]       regWrData;
	logic              regWr;
	logic              regRd;
	logic [31:0]       regRdData;
	logic              selectLineN;
	logic              spiClk;
	logic              spiMosi;
	logic              spiMiso;
	logic              spiMisoEn;
	logic [PTR_W-1:0]  memAddr;
	logic [7:0]        memWrData;
	logic              memWr;
	logic              memRd;
	logic [7:0]        memRdData;
	logic [7:0]        ram [0:255];
	int                failures;
	int                n_compared;

	spi_slave_dma DUT (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .selectLineN(selectLineN), .spiClk(spiClk),
		.spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoEn(spiMisoEn),
		.memAddr(memAddr), .memWrData(memWrData), .memWr(memWr),
		.memRd(memRd), .memRdData(memRdData));
	spi_master_model PM (.selectLineN(selectLineN), .spiClk(spiClk),
		.spiMosi(spiMosi), .spiMiso(spiMiso));

	always #12.5 ref_clk = !ref_clk;
	always @(posedge ref_clk) begin
		if (memWr)
			ram[memAddr[7:0]] <= memWrData;
		if (memRd)
			memRdData <= ram[memAddr[7:0]];
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'h1;
		@(posedge ref_clk);
		regWr <= 1'h0;
	endtask : wr

	task automatic rdChk(input string what, input logic [ADDR_W-1:0] a,
		input logic [31:0] exp);
		@(posedge ref_clk);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge ref_clk);
		regRd <= 1'h0;
		#1 check(what, regRdData, exp);
	endtask : rdChk

	task automatic runFrame(input int nBits, input logic [7:0] base);
		PM.sendQ.delete();
		for (int i = 0; i < 8; i++)
			PM.sendQ.push_back(base + i[7:0]);
		fork
			PM.frame(nBits);
			#300 check("miso enable", {31'h0, spiMisoEn}, 32'h1);
		join
		check("miso enable", {31'h0, spiMisoEn}, 32'h0);
	endtask : runFrame

	task automatic t_semaphore;
		wr(OFS_ENABLE, 32'h1);
		repeat (3) @(posedge ref_clk);
		rdChk("owner", OFS_SEM_STATE, 32'h1);
		rdChk("acquired", OFS_EV_ACQUIRED, 32'h0);
		rdChk("unmapped", 12'h7f0, 32'h0);
		wr(OFS_TASK_ACQUIRE, 32'h1);
		repeat (3) @(posedge ref_clk);
		rdChk("acquired", OFS_EV_ACQUIRED, 32'h1);
		wr(OFS_EV_ACQUIRED, 32'h0);
		wr(OFS_TASK_RELEASE, 32'h1);
		rdChk("owner", OFS_SEM_STATE, 32'h0);
		wr(OFS_TASK_RELEASE, 32'h1);
		rdChk("owner", OFS_SEM_STATE, 32'h0);
		rdChk("acquired", OFS_EV_ACQUIRED, 32'h0);
	endtask : t_semaphore

	task automatic t_modes;
		wr(OFS_RX_POINTER, 32'h40);
		wr(OFS_TX_POINTER, 32'h80);
		wr(OFS_RX_LIMIT, 32'h4);
		wr(OFS_TX_LIMIT, 32'h4);
		rdChk("tx pointer", OFS_TX_POINTER, 32'h80);
		for (int m = 0; m < 4; m++) begin
			wr(OFS_CONFIG, {29'h0, m[1:0], 1'h0});
			PM.setMode(m[1], m[0]);
			runFrame(32, 8'h10 + {6'h0, m[1:0]});
			for (int i = 0; i < 4; i++) begin
				check("tx byte", {24'h0, PM.gotQ[i]}, 32'ha0 + i);
				check("rx byte", {24'h0, ram[8'h40 + i[7:0]]},
					32'h10 + m + i);
			end
			rdChk("done", OFS_EV_DONE, 32'h1);
			rdChk("owner", OFS_SEM_STATE, 32'h0);
			rdChk("rx count", OFS_RX_COUNT, 32'h4);
			rdChk("tx count", OFS_TX_COUNT, 32'h4);
			rdChk("rx full", OFS_EV_RX_FULL, 32'h1);
			wr(OFS_EV_DONE, 32'h0);
			wr(OFS_EV_RX_FULL, 32'h0);
		end
		wr(OFS_CONFIG, 32'h0);
		PM.setMode(1'h0, 1'h0);
	endtask : t_modes

	task automatic t_limits;
		wr(OFS_RX_LIMIT, 32'h2);
		wr(OFS_TX_LIMIT, 32'h2);
		wr(OFS_TX_FLAG_A_FILL, 32'h5a);
		wr(OFS_CONFIG, 32'h1);
		ram[8'h42] = 8'hee;
		runFrame(28, 8'h70);
		check("tx byte", {24'h0, PM.gotQ[1]}, 32'h85);
		check("fill byte", {24'h0, PM.gotQ[2]}, 32'h5a);
		check("rx byte", {24'h0, ram[8'h41]}, 32'h8e);
		check("rx excess", {24'h0, ram[8'h42]}, 32'hee);
		rdChk("status", OFS_STATUS, 32'h3);
		rdChk("rx count", OFS_RX_COUNT, 32'h2);
		rdChk("tx count", OFS_TX_COUNT, 32'h2);
		rdChk("rx full", OFS_EV_RX_FULL, 32'h1);
		wr(OFS_STATUS, 32'h3);
		wr(OFS_EV_DONE, 32'h0);
		wr(OFS_CONFIG, 32'h0);
	endtask : t_limits

	task automatic t_ignored;
		wr(OFS_IGNORED_FILL, 32'hc3);
		wr(OFS_TASK_ACQUIRE, 32'h1);
		fork
			runFrame(24, 8'h90);
			begin
				#2000;
				wr(OFS_TASK_RELEASE, 32'h1);
			end
		join
		for (int i = 0; i < 3; i++)
			check("ignored fill", {24'h0, PM.gotQ[i]}, 32'hc3);
		check("rx kept", {24'h0, ram[8'h40]}, 32'h0e);
		rdChk("done", OFS_EV_DONE, 32'h0);
		rdChk("owner", OFS_SEM_STATE, 32'h0);
		rdChk("acquired", OFS_EV_ACQUIRED, 32'h1);
	endtask : t_ignored

	task automatic t_handover;
		for (int k = 1; k < 4; k++) begin
			wr(OFS_EV_ACQUIRED, 32'h0);
			wr(OFS_SHORTCUT, {31'h0, k[1]});
			fork
				runFrame(16, 8'h20);
				if (k[0]) begin
					#1500;
					wr(OFS_TASK_ACQUIRE, 32'h1);
				end
			join
			rdChk("owner", OFS_SEM_STATE, 32'h1);
			rdChk("acquired", OFS_EV_ACQUIRED, 32'h1);
			wr(OFS_EV_ACQUIRED, 32'h0);
			repeat (6) @(posedge ref_clk);
			rdChk("single", OFS_EV_ACQUIRED, 32'h0);
			wr(OFS_TASK_RELEASE, 32'h1);
		end
	endtask : t_handover

	task automatic tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	initial begin
		#400000;
		failures++;
		tally_and_finish();
	end

	initial begin
		ref_clk = 1'h0;
		rst_n = 1'h0;
		regAddr = '0;
		regWrData = 32'h0;
		regWr = 1'h0;
		regRd = 1'h0;
		memRdData = 8'h0;
		failures = 0;
		n_compared = 0;
		for (int i = 0; i < 256; i++)
			ram[i] = (i >= 8'h80) ? 8'ha0 + i[7:0] - 8'h80 : 8'h0;
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'h1;
		t_semaphore();
		t_modes();
		t_limits();
		t_ignored();
		t_handover();
		tally_and_finish();
	end
endmodule : spi_slave_semaphore_dma_tb_top
